//--- common/mmccb_consts.vh
// constants for the memory-mapped clock crossing bridge
// assumes inclusion by bare name from the bridge top design file
//
// Behaviour
// - one upstream slave port, one downstream master port
// - commands leave in acceptance order
// - commands and responses cross through async fifos
// - command fifo depth: power of two, 2..16384
// - response fifo depth: separate power of two
// - hold reads that would overflow response fifo
// - response depth defaults to twice max burst
// - data width power of two, 8..1024
// - symbol width 1..64 sets byte-enable lanes
// - address width configurable, 1..32 bits
// - optional automatic minimal address width
// - max burst power of two, 1..1024
// - downstream-bound synchronizers: 2..5 stages
// - upstream-bound synchronizers: 2..5 stages
// - each fifo half reset by its side
`ifndef MMCCB_CONSTS_VH
`define MMCCB_CONSTS_VH

// default build settings
`define MMCCB_DATA_W 32
`define MMCCB_SYMBOL_W 8
`define MMCCB_ADDR_W 32
`define MMCCB_SLAVE_SPAN 32'h0001_0000
`define MMCCB_MAX_BURST 8
`define MMCCB_BC_W 11
`define MMCCB_CMD_DEPTH 16
`define MMCCB_SYNC_STAGES 2

// apb register byte offsets
`define MMCCB_REG_CTRL 8'h00
`define MMCCB_REG_STATUS 8'h04

// control fields
`define MMCCB_CTRL_ISSUE_EN 0
`define MMCCB_CTRL_RESET 32'h0000_0001

// status fields
`define MMCCB_STAT_CMD_FULL 0
`define MMCCB_STAT_RESP_EMPTY 1
`define MMCCB_STAT_LEVEL_LSB 16

`endif

//--- core/mm_clock_crossing_bridge.v
// memory-mapped bridge between an upstream and a downstream clock domain
// assumes masters on the upstream port hold requests while waitrequest
// is high, and both domain resets are asserted together
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "mmccb_consts.vh"
module mm_clock_crossing_bridge
#(
	parameter DATA_W = `MMCCB_DATA_W,
	parameter SYMBOL_W = `MMCCB_SYMBOL_W,
	parameter BE_W = DATA_W / SYMBOL_W,
	parameter ADDR_W = `MMCCB_ADDR_W,
	parameter AUTO_ADDR = 0,
	parameter SLAVE_SPAN = `MMCCB_SLAVE_SPAN,
	parameter MAX_BURST = `MMCCB_MAX_BURST,
	parameter BC_W = `MMCCB_BC_W,
	parameter CMD_DEPTH = `MMCCB_CMD_DEPTH,
	parameter RESP_DEPTH = 2 * MAX_BURST,
	parameter MS_SYNC = `MMCCB_SYNC_STAGES,
	parameter SM_SYNC = `MMCCB_SYNC_STAGES
)
(
	input wire clk_i,
	input wire rst_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	input wire [ADDR_W-1:0] s_address_i,
	input wire s_read_i,
	input wire s_write_i,
	input wire [DATA_W-1:0] s_writedata_i,
	input wire [BE_W-1:0] s_byteenable_i,
	input wire [BC_W-1:0] s_burstcount_i,
	output wire s_waitrequest_o,
	output reg [DATA_W-1:0] s_readdata_o,
	output reg s_readdatavalid_o,
	input wire m_clk_i,
	input wire m_rst_n_i,
	output reg [ADDR_W-1:0] m_address_o,
	output reg m_read_o,
	output reg m_write_o,
	output reg [DATA_W-1:0] m_writedata_o,
	output reg [BE_W-1:0] m_byteenable_o,
	output reg [BC_W-1:0] m_burstcount_o,
	input wire m_waitrequest_i,
	input wire [DATA_W-1:0] m_readdata_i,
	input wire m_readdatavalid_i
);
	// ceiling log2 for depths and spans
	function integer clog2;
		input integer v;
		integer n;
		begin
			n = 0;
			while ((1 << n) < v)
				n = n + 1;
			clog2 = n;
		end
	endfunction

	// fifo pointer widths from the build-time depths
	localparam CAW = clog2(CMD_DEPTH);
	// response depth is its own setting, default 2 * max burst
	localparam RAW = clog2(RESP_DEPTH);
	// effective address width, minimal when automatic
	localparam EAW = AUTO_ADDR ? clog2(SLAVE_SPAN) : ADDR_W;
	// one command entry: read, write, burst, lanes, address, data
	localparam CW = 2 + BC_W + BE_W + ADDR_W + DATA_W;
	// outstanding-read arithmetic width, wide enough for a full burst
	localparam OW = ((RAW > BC_W) ? RAW : BC_W) + 2;

	// address bits kept; upper ones zero in automatic mode
	localparam [ADDR_W-1:0] ADDR_MASK =
		(EAW >= ADDR_W) ? {ADDR_W{1'b1}} :
		(({{(ADDR_W-1){1'b0}}, 1'b1} << EAW) - 1'b1);

	// upstream domain state
	reg [31:0] ctrl; // control register, issue enable
	wire cmd_full; // command fifo full, registered inside fifo
	wire [CAW:0] cmd_wlevel; // command words held, upstream view
	wire cmd_push; // command accepted on upstream port
	wire [CW-1:0] cmd_wdata; // packed command entry
	wire resp_empty; // no response word waiting upstream
	wire [DATA_W-1:0] resp_rdata; // head of response fifo
	wire [31:0] status; // live status word
	wire apb_setup; // setup phase of an apb transfer
	wire apb_write; // write takes effect at this edge

	// downstream domain state
	wire [CW-1:0] cmd_rdata; // head command entry
	wire cmd_empty; // no command waiting downstream
	wire issue_en_m; // issue enable seen downstream
	wire [RAW:0] resp_wlevel; // response words held, downstream view
	reg [OW-1:0] outstanding; // read words reserved, not yet returned
	wire head_read; // head command is a read
	wire [BC_W-1:0] head_burst; // head command burst length
	wire [OW-1:0] free_words; // response room left, conservative
	wire credit_ok; // head may go without overflowing responses
	wire cmd_done; // current downstream command accepted
	wire can_load; // output register free this cycle
	wire cmd_load; // pop head into the output register
	wire [OW-1:0] next_outstanding;

	// single upstream port stalls while the command fifo is full
	assign s_waitrequest_o = cmd_full;
	assign cmd_push = (s_read_i | s_write_i) & ~cmd_full;
	// a read burst is one entry; a write burst is one entry per beat
	assign cmd_wdata = {s_read_i, s_write_i, s_burstcount_i,
		s_byteenable_i, s_address_i & ADDR_MASK, s_writedata_i};

	// command fifo, single queue keeps acceptance order
	mmccb_async_fifo
	#(
		.W(CW),
		.DEPTH(CMD_DEPTH),
		.W2R_STAGES(MS_SYNC),
		.R2W_STAGES(SM_SYNC),
		.AW(CAW)
	)
	u_cmd_fifo
	(
		.wclk_i(clk_i),
		.wrst_n_i(rst_n_i),
		.push_i(cmd_push),
		.wdata_i(cmd_wdata),
		.full_o(cmd_full),
		.wlevel_o(cmd_wlevel),
		.rclk_i(m_clk_i),
		.rrst_n_i(m_rst_n_i),
		.pop_i(cmd_load),
		.rdata_o(cmd_rdata),
		.empty_o(cmd_empty)
	);

	// response fifo, downstream writes and upstream drains
	mmccb_async_fifo
	#(
		.W(DATA_W),
		.DEPTH(RESP_DEPTH),
		.W2R_STAGES(SM_SYNC),
		.R2W_STAGES(MS_SYNC),
		.AW(RAW)
	)
	u_resp_fifo
	(
		.wclk_i(m_clk_i),
		.wrst_n_i(m_rst_n_i),
		.push_i(m_readdatavalid_i),
		.wdata_i(m_readdata_i),
		.full_o(),
		.wlevel_o(resp_wlevel),
		.rclk_i(clk_i),
		.rrst_n_i(rst_n_i),
		.pop_i(~resp_empty),
		.rdata_o(resp_rdata),
		.empty_o(resp_empty)
	);

	// issue enable level crosses downstream with its own chain
	mmccb_sync_chain #(.W(1), .STAGES(MS_SYNC)) u_en_sync
	(
		.clk_i(m_clk_i),
		.rst_n_i(m_rst_n_i),
		.d_i(ctrl[`MMCCB_CTRL_ISSUE_EN]),
		.q_o(issue_en_m)
	);

	// upstream response path, one word per cycle when available
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s_readdata_o <= {DATA_W{1'b0}};
			s_readdatavalid_o <= 1'b0;
		end
		else
		begin
			s_readdatavalid_o <= ~resp_empty;
			s_readdata_o <= resp_rdata;
		end
	end

	// apb decode: answer prepared in setup, so no wait states
	assign apb_setup = psel_i & ~penable_i;
	assign apb_write = psel_i & penable_i & pready_o & pwrite_i;
	assign status = {{(16 - CAW - 1){1'b0}}, cmd_wlevel, 14'h0000,
		resp_empty, cmd_full};

	// apb slave: ready, read data and error for the access phase
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pready_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o <= apb_setup;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			if (apb_setup)
			begin
				case (paddr_i)
					`MMCCB_REG_CTRL:
						prdata_o <= pwrite_i ? 32'h0000_0000 : ctrl;
					`MMCCB_REG_STATUS:
						prdata_o <= pwrite_i ? 32'h0000_0000 : status;
					default:
						pslverr_o <= 1'b1; // unmapped address
				endcase
			end
		end
	end

	// control register write, only the enable bit is kept
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
			ctrl <= `MMCCB_CTRL_RESET;
		else if (apb_write && paddr_i == `MMCCB_REG_CTRL)
			ctrl <= pwdata_i & `MMCCB_CTRL_RESET;
	end

	// downstream issue decision
	assign head_read = cmd_rdata[CW-1];
	assign head_burst = cmd_rdata[CW-3 -: BC_W];
	assign free_words = RESP_DEPTH[OW-1:0]
		- {{(OW-RAW-1){1'b0}}, resp_wlevel};
	// reserve room for the whole read burst before issuing
	assign credit_ok = ~head_read ||
		(outstanding + {{(OW-BC_W){1'b0}}, head_burst} <= free_words);
	assign cmd_done = (m_read_o | m_write_o) & ~m_waitrequest_i;
	assign can_load = ~(m_read_o | m_write_o) | cmd_done;
	assign cmd_load = can_load & ~cmd_empty & issue_en_m & credit_ok;
	assign next_outstanding = outstanding
		+ ((cmd_load && head_read) ?
			{{(OW-BC_W){1'b0}}, head_burst} : {OW{1'b0}})
		- {{(OW-1){1'b0}}, m_readdatavalid_i};

	// read words reserved downstream and not yet returned
	always @(posedge m_clk_i)
	begin
		if (!m_rst_n_i)
			outstanding <= {OW{1'b0}};
		else
			outstanding <= next_outstanding;
	end

	// downstream command register, popped strictly in order
	always @(posedge m_clk_i)
	begin
		if (!m_rst_n_i)
		begin
			m_read_o <= 1'b0;
			m_write_o <= 1'b0;
			m_address_o <= {ADDR_W{1'b0}};
			m_writedata_o <= {DATA_W{1'b0}};
			m_byteenable_o <= {BE_W{1'b0}};
			m_burstcount_o <= {BC_W{1'b0}};
		end
		else if (cmd_load)
		begin
			// next entry in acceptance order
			{m_read_o, m_write_o, m_burstcount_o, m_byteenable_o,
				m_address_o, m_writedata_o} <= cmd_rdata;
		end
		else if (cmd_done)
		begin
			// accepted with nothing to follow: drop the request
			m_read_o <= 1'b0;
			m_write_o <= 1'b0;
		end
	end
endmodule // mm_clock_crossing_bridge

//--- core/mmccb_async_fifo.v
// dual-clock fifo with gray pointers and registered full and empty
// assumes both resets are asserted together by the surrounding system
`timescale 1ns/10ps
module mmccb_async_fifo
#(
	parameter W = 8,
	parameter DEPTH = 16,
	parameter W2R_STAGES = 2,
	parameter R2W_STAGES = 2,
	parameter AW = 4
)
(
	input wire wclk_i,
	input wire wrst_n_i,
	input wire push_i,
	input wire [W-1:0] wdata_i,
	output reg full_o,
	output reg [AW:0] wlevel_o,
	input wire rclk_i,
	input wire rrst_n_i,
	input wire pop_i,
	output wire [W-1:0] rdata_o,
	output reg empty_o
);
	reg [W-1:0] mem [0:DEPTH-1]; // storage, written in write domain only
	reg [AW:0] wbin; // write pointer, binary
	reg [AW:0] wgray; // write pointer, gray, crosses
	reg [AW:0] rbin; // read pointer, binary
	reg [AW:0] rgray; // read pointer, gray, crosses
	wire [AW:0] rgray_w; // read pointer seen in write domain
	wire [AW:0] wgray_r; // write pointer seen in read domain
	wire [AW:0] next_wbin;
	wire [AW:0] next_rbin;
	wire [AW:0] rbin_w;

	// gray to binary conversion
	function [AW:0] gray2bin;
		input [AW:0] g;
		integer i;
		begin
			gray2bin[AW] = g[AW];
			for (i = AW - 1; i >= 0; i = i - 1)
				gray2bin[i] = gray2bin[i + 1] ^ g[i];
		end
	endfunction

	// only gray pointers cross, each through its own chain
	mmccb_sync_chain #(.W(AW + 1), .STAGES(R2W_STAGES)) u_r2w
	(
		.clk_i(wclk_i),
		.rst_n_i(wrst_n_i),
		.d_i(rgray),
		.q_o(rgray_w)
	);
	mmccb_sync_chain #(.W(AW + 1), .STAGES(W2R_STAGES)) u_w2r
	(
		.clk_i(rclk_i),
		.rst_n_i(rrst_n_i),
		.d_i(wgray),
		.q_o(wgray_r)
	);

	assign rbin_w = gray2bin(rgray_w);
	assign next_wbin = wbin + {{AW{1'b0}}, push_i & ~full_o};
	assign next_rbin = rbin + {{AW{1'b0}}, pop_i & ~empty_o};
	// show-ahead read of an entry whose pointer has already crossed
	assign rdata_o = mem[rbin[AW-1:0]];

	// write half, reset by the write side's own reset
	always @(posedge wclk_i)
	begin
		if (!wrst_n_i)
		begin
			wbin <= {(AW + 1){1'b0}};
			wgray <= {(AW + 1){1'b0}};
			full_o <= 1'b0;
			wlevel_o <= {(AW + 1){1'b0}};
		end
		else
		begin
			wbin <= next_wbin;
			wgray <= next_wbin ^ (next_wbin >> 1);
			full_o <= (next_wbin - rbin_w) == DEPTH[AW:0];
			wlevel_o <= next_wbin - rbin_w;
		end
	end

	// storage write, no reset needed
	always @(posedge wclk_i)
	begin
		if (push_i && !full_o)
			mem[wbin[AW-1:0]] <= wdata_i;
	end

	// read half, reset by the read side's own reset
	always @(posedge rclk_i)
	begin
		if (!rrst_n_i)
		begin
			rbin <= {(AW + 1){1'b0}};
			rgray <= {(AW + 1){1'b0}};
			empty_o <= 1'b1;
		end
		else
		begin
			rbin <= next_rbin;
			rgray <= next_rbin ^ (next_rbin >> 1);
			empty_o <= (next_rbin ^ (next_rbin >> 1)) == wgray_r;
		end
	end
endmodule // mmccb_async_fifo

//--- core/mmccb_sync_chain.v
// multi-stage synchronizer for gray pointers and slow levels
// assumes d_i changes at most one bit per source clock (gray or level)
`timescale 1ns/10ps
module mmccb_sync_chain
#(
	parameter W = 1,
	parameter STAGES = 2
)
(
	input wire clk_i,
	input wire rst_n_i,
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	// stage k lives in bits [W*k +: W]; stage 0 is read only by stage 1
	reg [W*STAGES-1:0] chain;

	// shift toward the top stage each destination clock
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
			chain <= {W*STAGES{1'b0}};
		else
			chain <= {chain[W*(STAGES-1)-1:0], d_i};
	end

	assign q_o = chain[W*STAGES-1 -: W];
endmodule // mmccb_sync_chain

//--- tb/mmccb_checker.sv
// port-level assertions for the clock crossing bridge
// assumes binding onto the bridge top, two clock domains
`timescale 1ns/10ps
module mmccb_checker
#(
	parameter ADDR_W = 32,
	parameter DATA_W = 32,
	parameter BC_W = 11,
	parameter MAX_BURST = 8
)
(
	input wire clk_i,
	input wire rst_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire [7:0] paddr_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	input wire s_waitrequest_o,
	input wire s_readdatavalid_o,
	input wire m_clk_i,
	input wire m_rst_n_i,
	input wire [ADDR_W-1:0] m_address_o,
	input wire m_read_o,
	input wire m_write_o,
	input wire [DATA_W-1:0] m_writedata_o,
	input wire [BC_W-1:0] m_burstcount_o,
	input wire m_waitrequest_i
);
	// stalled downstream read keeps its command
	property p_hold;
		@(posedge m_clk_i) disable iff (!m_rst_n_i)
		m_read_o && m_waitrequest_i |=> m_read_o
		&& $stable(m_address_o) && $stable(m_burstcount_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read command changed while stalled");
	// stalled downstream write keeps its data
	property p_whold;
		@(posedge m_clk_i) disable iff (!m_rst_n_i)
		m_write_o && m_waitrequest_i |=> m_write_o
		&& $stable(m_writedata_o) && $stable(m_address_o);
	endproperty
	a_whold: assert property (p_whold)
		else $error("write command changed while stalled");
	// one command at a time on the downstream port
	property p_one;
		@(posedge m_clk_i) disable iff (!m_rst_n_i)
		!(m_read_o && m_write_o);
	endproperty
	a_one: assert property (p_one)
		else $error("read and write issued together");
	// issued read bursts stay within the supported length
	property p_burst;
		@(posedge m_clk_i) disable iff (!m_rst_n_i)
		m_read_o |-> m_burstcount_o >= 1 && m_burstcount_o <= MAX_BURST;
	endproperty
	a_burst: assert property (p_burst)
		else $error("burst length out of range");
	// upstream half cleared by its own reset
	property p_srst;
		@(posedge clk_i) !rst_n_i |=> !s_waitrequest_o && !s_readdatavalid_o;
	endproperty
	a_srst: assert property (p_srst)
		else $error("upstream outputs not cleared in reset");
	// downstream half cleared by its own reset
	property p_mrst;
		@(posedge m_clk_i) !m_rst_n_i |=> !m_read_o && !m_write_o;
	endproperty
	a_mrst: assert property (p_mrst)
		else $error("downstream command not cleared in reset");
	// register access answers in one cycle, for one cycle
	property p_rdy;
		@(posedge clk_i) disable iff (!rst_n_i)
		psel_i && !penable_i |=> pready_o ##1 !pready_o;
	endproperty
	a_rdy: assert property (p_rdy)
		else $error("register ready timing wrong");
	// unmapped offsets answer with error and zero data
	property p_err;
		@(posedge clk_i) disable iff (!rst_n_i)
		pready_o && paddr_i != 8'h00 && paddr_i != 8'h04
		|-> pslverr_o && prdata_o == 32'h0000_0000;
	endproperty
	a_err: assert property (p_err)
		else $error("unmapped access not refused");
endmodule // mmccb_checker

bind mm_clock_crossing_bridge mmccb_checker #(.ADDR_W(ADDR_W),
	.DATA_W(DATA_W), .BC_W(BC_W), .MAX_BURST(MAX_BURST)) u_chk (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o),
	.s_waitrequest_o(s_waitrequest_o),
	.s_readdatavalid_o(s_readdatavalid_o), .m_clk_i(m_clk_i),
	.m_rst_n_i(m_rst_n_i), .m_address_o(m_address_o),
	.m_read_o(m_read_o), .m_write_o(m_write_o),
	.m_writedata_o(m_writedata_o), .m_burstcount_o(m_burstcount_o),
	.m_waitrequest_i(m_waitrequest_i));

//--- tb/mmccb_slave_model.sv
// downstream memory slave, sixteen words, in-order read return
// assumes word index in address bits 3:0; slow_i stalls and spaces data
`timescale 1ns/10ps
module mmccb_slave_model
(
	input wire m_clk_i,
	input wire m_rst_n_i,
	input wire slow_i,
	input wire [31:0] addr_i,
	input wire rd_i,
	input wire wr_i,
	input wire [31:0] wdata_i,
	input wire [10:0] bc_i,
	output wire wait_o,
	output wire [31:0] rdata_o,
	output wire rvalid_o
);
	logic [31:0] mem [0:15]; // storage
	logic [31:0] q [$]; // words owed
	logic [31:0] dat; // last word sent
	logic [3:0] ph; // stall pattern
	logic v; // word valid
	assign wait_o = slow_i & ph[0];
	assign rvalid_o = v;
	// released data bus shows the inverse of the last word
	assign rdata_o = v ? dat : ~dat;
	// accept commands, return words in order
	always @(posedge m_clk_i)
	begin
		ph <= ph + 4'h1;
		v <= 1'b0;
		if (!m_rst_n_i)
			ph <= 4'h0;
		else
		begin
			if (wr_i && !wait_o)
				mem[addr_i[3:0]] <= wdata_i;
			if (rd_i && !wait_o)
				for (int i = 0; i < bc_i; i++)
					q.push_back(mem[addr_i[3:0] + 4'(i)]);
			if (q.size() > 0 && !(slow_i && ph[1]))
			begin
				v <= 1'b1;
				dat <= q.pop_front();
			end
		end
	end
endmodule // mmccb_slave_model

//--- tb/tb.sv
// self-checking bench: apb registers, upstream writes and bursts
// assumes the bridge with defaults and the downstream slave model
`timescale 1ns/10ps
module tb;
	logic clk_i = 0, m_clk_i = 0, rst_n_i = 0, m_rst_n_i = 0;
	logic psel_i = 0, penable_i = 0, pwrite_i = 0, slow = 0, se;
	logic [7:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, sd = 0, sa = 0, rd, exp_w [0:15];
	logic s_rd = 0, s_wr = 0;
	logic [3:0] sbe = 4'hf, m_be; // lanes sent and issued
	logic [10:0] sbc = 1, m_bc;
	logic [31:0] prdata_o, s_rdata, m_addr, m_wdata, m_rdata;
	logic pready_o, pslverr_o, s_wait, s_rv, m_rd, m_wr, m_wait, m_rv;
	logic [31:0] expq [$]; // words still owed upstream
	int bad_count = 0, num_checks = 0;
	mm_clock_crossing_bridge dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .s_address_i(sa),
		.s_read_i(s_rd), .s_write_i(s_wr), .s_writedata_i(sd),
		.s_byteenable_i(sbe), .s_burstcount_i(sbc),
		.s_waitrequest_o(s_wait), .s_readdata_o(s_rdata),
		.s_readdatavalid_o(s_rv), .m_clk_i(m_clk_i),
		.m_rst_n_i(m_rst_n_i), .m_address_o(m_addr), .m_read_o(m_rd),
		.m_write_o(m_wr), .m_writedata_o(m_wdata), .m_byteenable_o(m_be),
		.m_burstcount_o(m_bc), .m_waitrequest_i(m_wait),
		.m_readdata_i(m_rdata), .m_readdatavalid_i(m_rv));
	mmccb_slave_model slm (.m_clk_i(m_clk_i), .m_rst_n_i(m_rst_n_i),
		.slow_i(slow), .addr_i(m_addr), .rd_i(m_rd), .wr_i(m_wr),
		.wdata_i(m_wdata), .bc_i(m_bc), .wait_o(m_wait),
		.rdata_o(m_rdata), .rvalid_o(m_rv));
	initial forever #4 clk_i = ~clk_i;
	initial forever #5.5 m_clk_i = ~m_clk_i;
	// compare and count
	task chk(input string n, input logic [31:0] s, e);
		num_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// one apb transfer, held until ready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		// answer taken at the rising edge that sees ready high
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		se = pslverr_o;
		{psel_i, penable_i} <= 2'b00;
	endtask
	// one upstream request, held while stalled
	task mm(input logic r, input logic [31:0] a, d, input logic [10:0] c);
		@(posedge clk_i);
		{s_rd, s_wr, sa, sd, sbc, sbe} <= {r, !r, a, d, c, a[3:0] | 4'h1};
		// taken at the rising edge that sees waitrequest low
		do @(posedge clk_i); while (s_wait !== 1'b0);
		{s_rd, s_wr} <= 2'b00;
	endtask
	// lanes must travel with their write command
	always @(posedge m_clk_i)
		if (m_wr === 1'b1 && m_wait === 1'b0)
			chk("lanes", {28'h0, m_be},
				{28'h0, m_addr[3:0] | 4'h1});
	// read burst with its expected words queued
	task rdb(input int a, input int c);
		for (int i = 0; i < c; i++)
			expq.push_back(exp_w[a + i]);
		mm(1'b1, a, 32'h0000_0000, c);
	endtask
	// returned words against the queue
	always @(negedge clk_i)
		if (s_rv === 1'b1)
			chk("rdata", s_rdata, expq.size() ? expq.pop_front() : 'x);
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard
	initial
	begin
		#400000;
		bad_count++;
		conclude;
	end
	initial
	begin
		repeat (5) @(posedge clk_i);
		{rst_n_i, m_rst_n_i} <= 2'b11;
		apb(0, 8'h00, 0);
		chk("ctrl", rd, 32'h0000_0001);
		apb(1, 8'h04, 32'hffff_ffff);
		apb(0, 8'h04, 0);
		chk("status", rd, 32'h0000_0002);
		apb(0, 8'h08, 0);
		chk("err", {31'h0, se}, 32'h0000_0001);
		apb(1, 8'h00, 0);
		for (int i = 0; i < 16; i++)
		begin
			exp_w[i] = 32'h5a00_0000 + i;
			mm(1'b0, i, exp_w[i], 1);
		end
		@(negedge clk_i);
		chk("full", {31'h0, s_wait}, 32'h0000_0001);
		chk("held", {31'h0, m_wr}, 32'h0000_0000);
		apb(0, 8'h04, 0);
		chk("level", rd, 32'h0010_0003);
		slow <= 1'b1;
		apb(1, 8'h00, 1);
		for (int b = 0; b < 3; b++)
			rdb((b % 2) * 8, 8);
		slow <= 1'b0;
		rdb(3, 1);
		exp_w[5] = 32'h1234_5678;
		mm(1'b0, 5, exp_w[5], 1);
		rdb(5, 1);
		for (int n = 0; n < 3000 && expq.size() > 0; n++)
			@(negedge clk_i);
		chk("drain", expq.size(), 0);
		apb(0, 8'h04, 0);
		chk("idle", rd, 32'h0000_0002);
		conclude;
	end
endmodule // tb
